// file: core/acer_pkg.sv
/*
  Shared constants and carrier types for the converter channel
  enable register bank.
  Assumes a 32-bit Avalon-MM slave port with byte addresses.
*/
package acer_pkg;

  // register byte offsets
  localparam logic [7:0] ACER_OFF_CAPS = 8'h30;
  localparam logic [7:0] ACER_OFF_REV = 8'h34;
  localparam logic [7:0] ACER_OFF_EN = 8'h40;
  localparam logic [7:0] ACER_OFF_DIS = 8'h44;
  localparam logic [7:0] ACER_OFF_STATE = 8'h48;

  // channel positions, CH0..CH9
  localparam int ACER_NUM_CH = 10;
  localparam int ACER_CH_IDX_W = 4;
  localparam int ACER_TEMP_CH = 9;
  localparam int ACER_MISSING_CH = 3;
  localparam int ACER_NUM_PINS = 9;

  // fixed read values and reset values
  localparam logic [31:0] ACER_CAPS_VAL = 32'h000003ff;
  localparam logic [31:0] ACER_STATE_RST = 32'h00000000;
  localparam logic [31:0] ACER_RDATA_RST = 32'h00000000;

  // revision word layout
  localparam int ACER_REV_LSB = 0;
  localparam int ACER_REV_W = 12;
  localparam int ACER_VAR_LSB = 16;
  localparam int ACER_VAR_W = 4;

  typedef enum logic {
    ACER_IDLE,
    ACER_ACK
  } acer_bus_st_t;

  // one Avalon-MM request as driven by the master
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } acer_bus_req_t;

  // one channel's view of an access or a conversion
  typedef struct packed {
    logic set;
    logic clr;
    logic busy;
  } acer_cell_in_t;

endpackage

// file: core/acer_chan_cell.sv
/*
  One channel enable bit with its disturbance detector.
  Assumes set and clear are single-cycle strobes on ref_clk and that
  busy marks a conversion currently running on this channel.
*/
`timescale 1ns/10ps
module acer_chan_cell import acer_pkg::*; #(
  parameter bit IMPLEMENTED = 1'b1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // strobes
  input wire acer_cell_in_t cell_in,
  // state
  output logic en,
  output logic suspect
);

  typedef struct packed {
    logic en;
    logic suspect;
  } acer_cell_st_t;

  acer_cell_st_t st_ff;
  acer_cell_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.suspect = 1'b0;
    if (IMPLEMENTED) begin
      if (cell_in.clr) begin
        nxt_st.en = 1'b0;
      end
      if (cell_in.set) begin
        nxt_st.en = 1'b1;
      end
      // a set or clear of an enabled channel under its running conversion taints its result
      nxt_st.suspect = cell_in.busy & (cell_in.clr | cell_in.set)
        & st_ff.en;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign en = st_ff.en;
  assign suspect = st_ff.suspect;

endmodule

// file: core/acer_regs.sv
/*
  Channel enable register bank of the converter interface: capability,
  revision, enable, disable and channel state registers on Avalon-MM.
  Assumes a master on ref_clk that holds its request until it sees
  waitrequest low, and a conversion sequencer on the same clock.
*/
// Decided for this implementation: the Avalon-MM slave port.
// Summary of operation
// - A one written to a bit of channel_enable turns that channel on; zeros change nothing.
// - A one written to a bit of channel_disable turns that channel off; zeros change nothing.
// - Changing a channel's enable during its conversion leaves its data and flags undefined.
// - channel_state reads one for each enabled channel, resets to zero and follows writes.
// - The revision register shows a 12-bit revision low and a variant field above, with no effect.
// - There are ten channels: nine on analog pin positions and one on the temperature sensor.
// - Channel n uses pin n, channel nine the temperature sensor, and pin three does not exist.
// - The capability register reads a fixed value with bits zero to nine set.
// - A capability bit reads one when its channel exists and zero when it does not.
`timescale 1ns/10ps
module acer_regs import acer_pkg::*; #(
  // arbitrary identification values
  parameter logic [ACER_REV_W-1:0] REVISION = 12'h0a5,
  parameter logic [ACER_VAR_W-1:0] VARIANT = 4'h0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire acer_bus_req_t avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // conversion sequencer
  input wire logic conv_busy,
  input wire logic [ACER_CH_IDX_W-1:0] conv_chan,
  // channel controls
  output logic [ACER_NUM_CH-1:0] channel_enable_out,
  output logic [ACER_NUM_PINS-1:0] analog_pin_enable,
  output logic temp_sensor_enable,
  output logic [ACER_NUM_CH-1:0] result_suspect
);

  typedef struct packed {
    acer_bus_st_t bus;
    logic [31:0] rdata;
  } acer_regs_st_t;

  acer_regs_st_t st_ff;
  acer_regs_st_t nxt_st;

  logic req;
  logic accept;
  logic [31:0] lane_mask;
  logic [31:0] wbits;
  logic [ACER_NUM_CH-1:0] ch_en;
  logic [ACER_NUM_CH-1:0] ch_sus;
  logic [ACER_NUM_CH-1:0] set_v;
  logic [ACER_NUM_CH-1:0] clr_v;
  logic [31:0] state_word;
  logic [31:0] rev_word;

  // one wait state per access: the word is fetched before release
  assign req = avs_req.read | avs_req.write;
  assign accept = req & (st_ff.bus == ACER_ACK);
  assign avs_waitrequest = req & (st_ff.bus == ACER_IDLE);

  // only enabled byte lanes carry write ones
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane_mask[8*i +: 8] = {8{avs_req.byteenable[i]}};
    end
  end

  assign wbits = avs_req.writedata & lane_mask;

  always_comb begin
    set_v = '0;
    clr_v = '0;
    if (accept && avs_req.write) begin
      if (avs_req.address == ACER_OFF_EN) begin
        set_v = wbits[ACER_NUM_CH-1:0];
      end
      if (avs_req.address == ACER_OFF_DIS) begin
        clr_v = wbits[ACER_NUM_CH-1:0];
      end
    end
  end

  // one cell per channel position; the capability word says which exist
  genvar g;
  generate
    for (g = 0; g < ACER_NUM_CH; g++) begin : g_ch
      acer_cell_in_t cin;
      assign cin.set = set_v[g];
      assign cin.clr = clr_v[g];
      assign cin.busy = conv_busy
        && (conv_chan == ACER_CH_IDX_W'(g));
      acer_chan_cell #(
        .IMPLEMENTED(ACER_CAPS_VAL[g])
      ) u_cell (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .cell_in(cin),
        .en(ch_en[g]),
        .suspect(ch_sus[g])
      );
    end
  endgenerate

  assign state_word = ACER_STATE_RST
    | {{(32-ACER_NUM_CH){1'b0}}, ch_en};

  always_comb begin
    rev_word = '0;
    rev_word[ACER_REV_LSB +: ACER_REV_W] = REVISION;
    rev_word[ACER_VAR_LSB +: ACER_VAR_W] = VARIANT;
  end

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff.bus)
      ACER_IDLE: begin
        if (req) begin
          nxt_st.bus = ACER_ACK;
          nxt_st.rdata = ACER_RDATA_RST;
          if (avs_req.read) begin
            unique case (avs_req.address)
              ACER_OFF_CAPS: nxt_st.rdata = ACER_CAPS_VAL;
              ACER_OFF_REV: nxt_st.rdata = rev_word;
              ACER_OFF_STATE: nxt_st.rdata = state_word;
              // write-only and unmapped words read zero
              default: nxt_st.rdata = ACER_RDATA_RST;
            endcase
          end
        end
      end
      ACER_ACK: begin
        nxt_st.bus = ACER_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff.bus <= ACER_IDLE;
      st_ff.rdata <= ACER_RDATA_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign avs_readdata = st_ff.rdata;
  assign channel_enable_out = ch_en;
  assign result_suspect = ch_sus;

  // pin n follows channel n; pin three is absent, so never driven
  always_comb begin
    analog_pin_enable = ch_en[ACER_NUM_PINS-1:0];
    analog_pin_enable[ACER_MISSING_CH] = 1'b0;
  end

  assign temp_sensor_enable = ch_en[ACER_TEMP_CH];

  // checks

  property p_wait_bounded;
    @(posedge ref_clk) disable iff (!rst_n)
      req |-> ##[0:1] !avs_waitrequest;
  endproperty
  a_wait_bounded: assert property (p_wait_bounded)
    else $error("waitrequest held too long");

  property p_enable_sets;
    @(posedge ref_clk) disable iff (!rst_n)
      (accept && avs_req.write && avs_req.address == ACER_OFF_EN
        && avs_req.byteenable[0] && avs_req.writedata[0])
      |=> ch_en[0];
  endproperty
  a_enable_sets: assert property (p_enable_sets)
    else $error("enable write did not set channel");

  property p_enable_zero_keeps;
    @(posedge ref_clk) disable iff (!rst_n)
      (accept && avs_req.write && avs_req.address == ACER_OFF_EN
        && avs_req.writedata == 32'h0)
      |=> $stable(ch_en);
  endproperty
  a_enable_zero_keeps: assert property (p_enable_zero_keeps)
    else $error("zero enable write changed channels");

  property p_disable_clears;
    @(posedge ref_clk) disable iff (!rst_n)
      (accept && avs_req.write && avs_req.address == ACER_OFF_DIS
        && avs_req.byteenable[1] && avs_req.writedata[8])
      |=> !ch_en[8];
  endproperty
  a_disable_clears: assert property (p_disable_clears)
    else $error("disable write did not clear channel");

  property p_disable_zero_keeps;
    @(posedge ref_clk) disable iff (!rst_n)
      (accept && avs_req.write && avs_req.address == ACER_OFF_DIS
        && avs_req.writedata == 32'h0)
      |=> $stable(ch_en);
  endproperty
  a_disable_zero_keeps: assert property (p_disable_zero_keeps)
    else $error("zero disable write changed channels");

  property p_suspect_flag;
    @(posedge ref_clk) disable iff (!rst_n)
      (conv_busy && conv_chan == 4'h1 && ch_en[1] && clr_v[1])
      |=> result_suspect[1] ##1 !result_suspect[1];
  endproperty
  a_suspect_flag: assert property (p_suspect_flag)
    else $error("disturbed conversion not flagged");

  property p_state_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (accept && avs_req.read && avs_req.address == ACER_OFF_STATE)
      |-> avs_readdata == {22'h0, ch_en};
  endproperty
  a_state_read: assert property (p_state_read)
    else $error("channel state readback wrong");

  property p_rev_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (accept && avs_req.read && avs_req.address == ACER_OFF_REV)
      |-> avs_readdata[11:0] == REVISION
        && avs_readdata[31:20] == 12'h0
        && avs_readdata[15:12] == 4'h0;
  endproperty
  a_rev_read: assert property (p_rev_read)
    else $error("revision readback wrong");

  property p_caps_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (accept && avs_req.read && avs_req.address == ACER_OFF_CAPS)
      |-> avs_readdata == 32'h000003ff;
  endproperty
  a_caps_read: assert property (p_caps_read)
    else $error("capability readback wrong");

  property p_pin_map;
    @(posedge ref_clk) disable iff (!rst_n)
      !analog_pin_enable[3]
      && analog_pin_enable[2] == ch_en[2]
      && temp_sensor_enable == ch_en[9];
  endproperty
  a_pin_map: assert property (p_pin_map)
    else $error("pin mapping wrong");

  property p_reset_state;
    @(posedge ref_clk)
      !rst_n |=> ch_en == 10'h0 || !rst_n;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("channels not cleared by reset");

  // read data stand until the next request is seen in the idle state
  property p_rdata_stands;
    @(posedge ref_clk) disable iff (!rst_n)
      !(req && st_ff.bus == ACER_IDLE)
      |=> $stable(avs_readdata);
  endproperty
  a_rdata_stands: assert property (p_rdata_stands)
    else $error("read data changed without a request");

  // a request is never taken in its first cycle
  property p_first_cycle_waits;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(req) |-> avs_waitrequest;
  endproperty
  a_first_cycle_waits: assert property (p_first_cycle_waits)
    else $error("request taken without a wait state");

  property p_unmapped_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (accept && avs_req.read && avs_req.address != ACER_OFF_CAPS
        && avs_req.address != ACER_OFF_REV
        && avs_req.address != ACER_OFF_STATE)
      |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("write-only or unmapped word read nonzero");

  // channel state moves only on an accepted write
  property p_state_holds;
    @(posedge ref_clk) disable iff (!rst_n)
      !accept |=> $stable(ch_en);
  endproperty
  a_state_holds: assert property (p_state_holds)
    else $error("channel state changed without a write");

  property p_enable_only_sets;
    @(posedge ref_clk) disable iff (!rst_n)
      (accept && avs_req.write && avs_req.address == ACER_OFF_EN)
      |=> (ch_en & $past(ch_en)) == $past(ch_en);
  endproperty
  a_enable_only_sets: assert property (p_enable_only_sets)
    else $error("enable write cleared a channel");

  property p_disable_only_clears;
    @(posedge ref_clk) disable iff (!rst_n)
      (accept && avs_req.write && avs_req.address == ACER_OFF_DIS)
      |=> (ch_en & ~$past(ch_en)) == 10'h0;
  endproperty
  a_disable_only_clears: assert property (p_disable_only_clears)
    else $error("disable write set a channel");

  property p_temp_enable;
    @(posedge ref_clk) disable iff (!rst_n)
      (accept && avs_req.write && avs_req.address == ACER_OFF_EN
        && avs_req.byteenable[1] && avs_req.writedata[9])
      |=> ch_en[ACER_TEMP_CH] && temp_sensor_enable;
  endproperty
  a_temp_enable: assert property (p_temp_enable)
    else $error("temperature channel not enabled");

  // a change with no conversion running never taints a result
  property p_suspect_quiet;
    @(posedge ref_clk) disable iff (!rst_n)
      !conv_busy |=> result_suspect == 10'h0;
  endproperty
  a_suspect_quiet: assert property (p_suspect_quiet)
    else $error("suspect raised with no conversion");

  property p_suspect_enabled;
    @(posedge ref_clk) disable iff (!rst_n)
      (result_suspect & ~$past(ch_en)) == 10'h0;
  endproperty
  a_suspect_enabled: assert property (p_suspect_enabled)
    else $error("suspect raised for a disabled channel");

  property p_suspect_single;
    @(posedge ref_clk) disable iff (!rst_n)
      result_suspect != 10'h0 |=> result_suspect == 10'h0;
  endproperty
  a_suspect_single: assert property (p_suspect_single)
    else $error("suspect pulse longer than one cycle");

  property p_pins_follow;
    @(posedge ref_clk) disable iff (!rst_n)
      analog_pin_enable[8:4] == ch_en[8:4]
      && analog_pin_enable[1:0] == ch_en[1:0];
  endproperty
  a_pins_follow: assert property (p_pins_follow)
    else $error("analog pin enable does not follow channel");

  // held reset: read data and pulses are cleared as well
  property p_reset_outputs;
    @(posedge ref_clk)
      (!rst_n ##1 !rst_n)
      |-> avs_readdata == 32'h0 && result_suspect == 10'h0;
  endproperty
  a_reset_outputs: assert property (p_reset_outputs)
    else $error("outputs not cleared during reset");

endmodule

// file: dv/acer_regs_bench.sv
/*
  Self-checking bench for the channel enable register bank.
  Assumes the design files under core/ are compiled first.
*/
`timescale 1ns/10ps
module acer_regs_bench import acer_pkg::*; ();
  // arbitrary identification values
  localparam logic [ACER_REV_W-1:0] REV_P = 12'h5c3;
  localparam logic [ACER_VAR_W-1:0] VAR_P = 4'h2;
  localparam logic [31:0] EXP_REV = (32'(VAR_P) << ACER_VAR_LSB) |
                                    (32'(REV_P) << ACER_REV_LSB);
  localparam logic [7:0] RD_ADDR [4] = '{ACER_OFF_REV, ACER_OFF_EN,
                                         ACER_OFF_DIS, 8'h4c};
  localparam logic [31:0] RD_EXP [4] = '{EXP_REV, 32'h0, 32'h0, 32'h0};

  logic ref_clk;
  logic rst_n;
  acer_bus_req_t avs_req;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic conv_busy;
  logic [ACER_CH_IDX_W-1:0] conv_chan;
  logic [ACER_NUM_CH-1:0] channel_enable_out;
  logic [ACER_NUM_PINS-1:0] analog_pin_enable;
  logic temp_sensor_enable;
  logic [ACER_NUM_CH-1:0] result_suspect;
  logic [31:0] rd;
  int mismatches;
  int checks;

  acer_regs #(.REVISION(REV_P), .VARIANT(VAR_P)) i_dut (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .avs_req(avs_req),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .conv_busy(conv_busy),
    .conv_chan(conv_chan),
    .channel_enable_out(channel_enable_out),
    .analog_pin_enable(analog_pin_enable),
    .temp_sensor_enable(temp_sensor_enable),
    .result_suspect(result_suspect)
  );

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one Avalon-MM access; waitrequest is judged at the negedge before
  // the sampling edge so the combinational output is settled
  task automatic bus(input logic r, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    avs_req <= '{read: r, write: ~r, address: a, writedata: d,
                 byteenable: be};
    for (n = 0; n < 20; n++) begin
      @(negedge ref_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 20) begin
      mismatches = mismatches + 1;
      $display("wrong value at %0t: got %h expected %h", $time, 1'b1, 1'b0);
      results();
    end
    q = avs_readdata;
    @(posedge ref_clk);
    avs_req <= '0;
  endtask

  task automatic chk_state(input logic [ACER_NUM_CH-1:0] e);
    logic [31:0] q;
    @(negedge ref_clk);
    chk(32'(channel_enable_out), 32'(e));
    chk(32'(analog_pin_enable),
        32'(e[ACER_NUM_PINS-1:0] & ~(9'h1 << ACER_MISSING_CH)));
    chk(32'(temp_sensor_enable), 32'(e[ACER_TEMP_CH]));
    bus(1'b1, ACER_OFF_STATE, 32'h0, 4'hf, q);
    chk(q, 32'(e));
  endtask

  task automatic sus_case(input logic b, input logic [3:0] c,
                          input logic [31:0] d, input logic [9:0] e);
    logic [ACER_NUM_CH-1:0] acc;
    int cnt;
    acc = '0;
    cnt = 0;
    @(posedge ref_clk);
    conv_busy <= b;
    conv_chan <= c;
    bus(1'b0, ACER_OFF_DIS, d, 4'hf, rd);
    // the pulse stands in the cycle after the accepting edge
    repeat (3) begin
      @(negedge ref_clk);
      acc = acc | result_suspect;
      if (result_suspect !== '0) begin
        cnt = cnt + 1;
      end
    end
    chk(32'(acc), 32'(e));
    chk(32'(cnt), (e != '0) ? 32'h1 : 32'h0);
  endtask

  initial begin
    rst_n = 1'b0;
    avs_req = '0;
    conv_busy = 1'b0;
    conv_chan = '0;
    mismatches = 0;
    checks = 0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk_state(10'h000);
    bus(1'b1, ACER_OFF_CAPS, 32'h0, 4'hf, rd);
    chk(rd, 32'h000003ff);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, RD_ADDR[i], 32'h0, 4'hf, rd);
      chk(rd, RD_EXP[i]);
    end
    $display("test reset values done");
    bus(1'b0, ACER_OFF_EN, 32'hffffffff, 4'hf, rd);
    chk_state(10'h3ff);
    bus(1'b0, ACER_OFF_DIS, 32'h00000005, 4'hf, rd);
    chk_state(10'h3fa);
    bus(1'b0, ACER_OFF_EN, 32'h0, 4'hf, rd);
    bus(1'b0, ACER_OFF_DIS, 32'h0, 4'hf, rd);
    chk_state(10'h3fa);
    bus(1'b0, ACER_OFF_DIS, 32'h00000300, 4'h1, rd);
    chk_state(10'h3fa);
    bus(1'b0, ACER_OFF_DIS, 32'h00000300, 4'h2, rd);
    chk_state(10'h0fa);
    bus(1'b0, 8'h4c, 32'hffffffff, 4'hf, rd);
    bus(1'b0, ACER_OFF_STATE, 32'h0, 4'hf, rd);
    bus(1'b0, ACER_OFF_EN, 32'h00000001, 4'hf, rd);
    chk_state(10'h0fb);
    $display("test enable and disable done");
    sus_case(1'b1, 4'd1, 32'h00000020, 10'h000);
    sus_case(1'b0, 4'd3, 32'h00000008, 10'h000);
    sus_case(1'b1, 4'd1, 32'h00000002, 10'h002);
    @(posedge ref_clk);
    conv_busy <= 1'b0;
    chk_state(10'h0d1);
    $display("test conversion disturbance done");
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk_state(10'h000);
    $display("test second reset done");
    results();
  end
endmodule
